/* File: design/dscidt_decode.v */
// instruction decode and cycle timing for the 16-bit signal controller
// assumes program memory holds a word on instr_word while instr_valid
`timescale 1ns/100ps
`include "dscidt_map.vh"

// Overview of operation
// RL1: one 24-bit program word per instruction
// RL2: 8-bit opcode, remaining bits are operands
// RL3: two-word instructions, both words combined into 48 bits
// RL4: second word carries zero upper 8 bits
// RL5: lone second word executes as no-op
// RL6: one cycle, two when condition/PC changes
// RL7: branches, calls, tables, returns take 2-3
// RL8: taken skip: 2 cycles, 3 over two-word
// RL9: double moves and two-word instructions: 2 cycles
// RL10: base, source and destination registers decoded
// RL11: file address and file-or-register-zero destination
// RL12: bit from literal or base register
// RL13: literal result to base unless separate destination
// RL14: accumulator, multiplier pair, prefetches, write-back
// RL15: shift amount from register or literal
// RL16: write-back only W13 or [W13]+=2
// RL17: 4-bit bit selection, positions 0-15
// RL18: 10-bit literal limited to 255 bytewise
// RL19: 23-bit program address lsb always zero
// RL20: carry, digit carry, negative, overflow, sticky zero
// RL21: accumulator overflow and saturate flags A, B
// RL22: byte, word, double, shadow; word default
module dscidt_decode #(
    parameter IW = 24
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire [IW-1:0] instr_word,
    input wire instr_valid,
    input wire cond_true,
    input wire next_two_word,
    input wire [3:0] mcu_flag_we,
    input wire [3:0] mcu_flag_val,
    input wire zero_we,
    input wire result_zero,
    input wire [3:0] dsp_flag_we,
    input wire [3:0] dsp_flag_val,
    output reg fetch_rdy_q,
    output reg dec_valid_q,
    output reg nop_q,
    output reg [7:0] opcode_q,
    output reg [3:0] instr_class_q,
    output reg [47:0] long_instr_q,
    output reg [1:0] cycles_q,
    output reg pc_change_q,
    output reg [3:0] base_work_reg_q,
    output reg [3:0] source_work_reg_q,
    output reg [2:0] src_mode_q,
    output reg [3:0] dest_work_reg_q,
    output reg [2:0] dest_mode_q,
    output reg [12:0] file_addr_q,
    output reg dest_default_accum_reg_zero_q,
    output reg [3:0] bit_select_field_q,
    output reg bit_indirect_q,
    output reg [9:0] unsigned_literal_ten_q,
    output reg lit_range_err_q,
    output reg [22:0] unsigned_literal_twentythree_q,
    output reg addr_lsb_err_q,
    output reg word2_err_q,
    output reg acc_sel_q,
    output reg [2:0] mul_pair_q,
    output reg [3:0] xpf_q,
    output reg [3:0] ypf_q,
    output reg [1:0] acc_writeback_dest_q,
    output reg shift_from_reg_q,
    output reg [5:0] shift_amount_q,
    output reg [1:0] size_q,
    output reg shadow_q,
    output reg [3:0] mcu_flags_q,
    output reg zero_flag_q,
    output reg [3:0] dsp_flags_q
);

localparam S_FETCH = 2'h0;
localparam S_WORD2 = 2'h1;
localparam S_STALL = 2'h2;

reg [1:0] state_q;
reg [1:0] stall_q;
reg [23:0] word1_q;
wire [23:0] w = instr_word[23:0];
wire [3:0] cls = w[`DSCIDT_CLS_MSB:`DSCIDT_CLS_LSB];
wire take = ce && instr_valid && fetch_rdy_q;

reg [1:0] cyc_d;
reg pcc_d;
reg [1:0] size_d;
reg [1:0] wbk_d;
reg [3:0] dst_d;
reg [2:0] dmode_d;

// cycle cost of a single-word instruction
always @* begin
    cyc_d = `DSCIDT_CYC_ONE; // RL6
    pcc_d = 1'b0;
    case (cls)
        `DSCIDT_CLS_BRANCH_OP, `DSCIDT_CLS_CALLIND: begin
            cyc_d = `DSCIDT_CYC_TWO; // RL7
            pcc_d = 1'b1;
        end
        `DSCIDT_CLS_TABLE: begin
            cyc_d = `DSCIDT_CYC_TWO; // RL7
        end
        `DSCIDT_CLS_RETURN: begin
            // interrupt return also restores context, one more cycle
            cyc_d = w[`DSCIDT_RETI_BIT] ? `DSCIDT_CYC_THREE :
                `DSCIDT_CYC_TWO; // RL7
            pcc_d = 1'b1;
        end
        `DSCIDT_CLS_BRCOND: begin
            cyc_d = cond_true ? `DSCIDT_CYC_TWO : `DSCIDT_CYC_ONE; // RL6
            pcc_d = cond_true;
        end
        `DSCIDT_CLS_SKIP: begin
            if (cond_true) begin
                cyc_d = next_two_word ? `DSCIDT_CYC_THREE :
                    `DSCIDT_CYC_TWO; // RL8
                pcc_d = 1'b1;
            end
        end
        `DSCIDT_CLS_MOVD: begin
            cyc_d = `DSCIDT_CYC_TWO; // RL9
        end
        default: begin
            cyc_d = `DSCIDT_CYC_ONE;
        end
    endcase
end

// operand size and write-back decode
always @* begin
    case (w[`DSCIDT_SIZE_LSB+1:`DSCIDT_SIZE_LSB])
        `DSCIDT_SIZE_BYTE: size_d = `DSCIDT_SIZE_BYTE; // RL22
        `DSCIDT_SIZE_DBL: size_d = `DSCIDT_SIZE_DBL; // RL22
        default: size_d = `DSCIDT_SIZE_WORD; // RL22
    endcase
    case (w[`DSCIDT_WBK_LSB+1:`DSCIDT_WBK_LSB])
        `DSCIDT_WBK_W13: wbk_d = `DSCIDT_WBK_W13; // RL16
        `DSCIDT_WBK_W13PI: wbk_d = `DSCIDT_WBK_W13PI; // RL16
        default: wbk_d = `DSCIDT_WBK_NONE; // RL16
    endcase
    // literal forms write back to the base unless told otherwise
    if (cls == `DSCIDT_CLS_LITAR && !w[`DSCIDT_LSEP_BIT]) begin
        dst_d = w[`DSCIDT_BASE_MSB:`DSCIDT_BASE_LSB]; // RL13
        dmode_d = 3'h0;
    end else if (cls == `DSCIDT_CLS_LITAR) begin
        dst_d = w[`DSCIDT_LDST_LSB+3:`DSCIDT_LDST_LSB]; // RL13
        dmode_d = 3'h0;
    end else begin
        dst_d = w[`DSCIDT_DST_LSB+3:`DSCIDT_DST_LSB]; // RL10
        dmode_d = w[`DSCIDT_DMODE_LSB+2:`DSCIDT_DMODE_LSB]; // RL10
    end
end

// fetch sequencer and registered operand fields
always @(posedge mclk) begin
    if (rst) begin
        state_q <= S_FETCH;
        stall_q <= 2'h0;
        word1_q <= 24'h000000;
        fetch_rdy_q <= 1'b1;
        dec_valid_q <= 1'b0;
        nop_q <= 1'b0;
        opcode_q <= 8'h00;
        instr_class_q <= 4'h0;
        long_instr_q <= 48'h000000000000;
        cycles_q <= 2'h0;
        pc_change_q <= 1'b0;
        base_work_reg_q <= 4'h0;
        source_work_reg_q <= 4'h0;
        src_mode_q <= 3'h0;
        dest_work_reg_q <= 4'h0;
        dest_mode_q <= 3'h0;
        file_addr_q <= 13'h0000;
        dest_default_accum_reg_zero_q <= 1'b0;
        bit_select_field_q <= 4'h0;
        bit_indirect_q <= 1'b0;
        unsigned_literal_ten_q <= 10'h000;
        lit_range_err_q <= 1'b0;
        unsigned_literal_twentythree_q <= 23'h000000;
        addr_lsb_err_q <= 1'b0;
        word2_err_q <= 1'b0;
        acc_sel_q <= 1'b0;
        mul_pair_q <= 3'h0;
        xpf_q <= 4'h0;
        ypf_q <= 4'h0;
        acc_writeback_dest_q <= `DSCIDT_WBK_NONE;
        shift_from_reg_q <= 1'b0;
        shift_amount_q <= 6'h00;
        size_q <= `DSCIDT_SIZE_WORD;
        shadow_q <= 1'b0;
    end else if (ce) begin
        dec_valid_q <= 1'b0;
        case (state_q)
            S_FETCH: begin
                if (take && cls == `DSCIDT_CLS_TWOWORD) begin
                    word1_q <= w; // RL3
                    state_q <= S_WORD2;
                end else if (take) begin
                    dec_valid_q <= 1'b1; // RL1
                    opcode_q <= w[`DSCIDT_OPC_MSB:`DSCIDT_OPC_LSB]; // RL2
                    instr_class_q <= cls; // RL5
                    long_instr_q <= {24'h000000, w};
                    cycles_q <= cyc_d;
                    pc_change_q <= pcc_d;
                    base_work_reg_q <=
                        w[`DSCIDT_BASE_MSB:`DSCIDT_BASE_LSB]; // RL10
                    source_work_reg_q <=
                        w[`DSCIDT_SRC_LSB+3:`DSCIDT_SRC_LSB]; // RL10
                    src_mode_q <=
                        w[`DSCIDT_SMODE_LSB+2:`DSCIDT_SMODE_LSB];
                    dest_work_reg_q <= dst_d;
                    dest_mode_q <= dmode_d;
                    file_addr_q <= w[12:0]; // RL11
                    dest_default_accum_reg_zero_q <=
                        w[`DSCIDT_FWREG_BIT]; // RL11
                    bit_select_field_q <=
                        w[`DSCIDT_BITSEL_LSB+3:`DSCIDT_BITSEL_LSB]; // RL17
                    bit_indirect_q <= w[`DSCIDT_BITIND_BIT]; // RL12
                    unsigned_literal_ten_q <= w[9:0];
                    lit_range_err_q <= cls == `DSCIDT_CLS_LITAR &&
                        w[`DSCIDT_LBYTE_BIT] &&
                        w[9:0] > `DSCIDT_BYTE_LIT_MAX; // RL18
                    acc_sel_q <= w[`DSCIDT_ACC_BIT]; // RL14
                    mul_pair_q <=
                        w[`DSCIDT_MPAIR_LSB+2:`DSCIDT_MPAIR_LSB]; // RL14
                    xpf_q <= w[`DSCIDT_XPF_LSB+3:`DSCIDT_XPF_LSB]; // RL14
                    ypf_q <= w[`DSCIDT_YPF_LSB+3:`DSCIDT_YPF_LSB]; // RL14
                    acc_writeback_dest_q <= wbk_d; // RL16
                    shift_from_reg_q <= w[`DSCIDT_SHREG_BIT]; // RL15
                    shift_amount_q <= w[5:0]; // RL15
                    // literal forms carry a byte flag, not a size field
                    size_q <= cls == `DSCIDT_CLS_LITAR ?
                        (w[`DSCIDT_LBYTE_BIT] ? `DSCIDT_SIZE_BYTE :
                        `DSCIDT_SIZE_WORD) : size_d; // RL22
                    shadow_q <= cls == `DSCIDT_CLS_RETURN && w[0]; // RL22
                    if (cyc_d != `DSCIDT_CYC_ONE) begin
                        // extra cycles are no-ops, fetch held off
                        stall_q <= cyc_d - 2'h1; // RL6
                        fetch_rdy_q <= 1'b0;
                        nop_q <= 1'b1;
                        state_q <= S_STALL;
                    end
                end
            end
            S_WORD2: begin
                if (take) begin
                    // word fetch itself is the second cycle
                    dec_valid_q <= 1'b1;
                    opcode_q <=
                        word1_q[`DSCIDT_OPC_MSB:`DSCIDT_OPC_LSB];
                    instr_class_q <= `DSCIDT_CLS_TWOWORD;
                    base_work_reg_q <=
                        word1_q[`DSCIDT_BASE_MSB:`DSCIDT_BASE_LSB]; // RL10
                    long_instr_q <= {word1_q, w}; // RL3
                    cycles_q <= `DSCIDT_CYC_TWO; // RL9
                    pc_change_q <= 1'b1;
                    word2_err_q <= w[23:16] != 8'h00; // RL4
                    unsigned_literal_twentythree_q <=
                        {word1_q[6:0], w[15:1], 1'b0}; // RL19
                    addr_lsb_err_q <= w[0]; // RL19
                    state_q <= S_FETCH;
                end
            end
            S_STALL: begin
                if (stall_q == 2'h1) begin
                    fetch_rdy_q <= 1'b1;
                    nop_q <= 1'b0;
                    state_q <= S_FETCH;
                end
                stall_q <= stall_q - 2'h1;
            end
            default: begin
                state_q <= S_FETCH;
                fetch_rdy_q <= 1'b1;
                nop_q <= 1'b0;
            end
        endcase
    end
end

// status flags, one slice per bit
// sticky zero starts set and only clears: a chain reads zero only if
// every step of it gave zero
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
        always @(posedge mclk) begin
            if (rst) begin
                mcu_flags_q[gi] <= 1'b0;
                dsp_flags_q[gi] <= 1'b0;
            end else if (ce) begin
                if (mcu_flag_we[gi])
                    mcu_flags_q[gi] <= mcu_flag_val[gi]; // RL20
                if (dsp_flag_we[gi])
                    dsp_flags_q[gi] <= dsp_flag_val[gi]; // RL21
            end
        end
    end
endgenerate

always @(posedge mclk) begin
    if (rst)
        zero_flag_q <= `DSCIDT_RST_ZERO;
    else if (ce && zero_we && !result_zero)
        zero_flag_q <= 1'b0; // RL20
end

endmodule

/* File: design/dscidt_map.vh */
// constants for the instruction decode and cycle timing block
// assumes 24-bit program words presented one per accepted fetch
`ifndef DSCIDT_MAP_VH
`define DSCIDT_MAP_VH
`define DSCIDT_OPC_MSB 23
`define DSCIDT_OPC_LSB 16
`define DSCIDT_CLS_MSB 23
`define DSCIDT_CLS_LSB 20
`define DSCIDT_BASE_MSB 19
`define DSCIDT_BASE_LSB 16
`define DSCIDT_CLS_NOP 4'h0
`define DSCIDT_CLS_REG3 4'h1
`define DSCIDT_CLS_FILE 4'h2
`define DSCIDT_CLS_BIT 4'h3
`define DSCIDT_CLS_LITAR 4'h4
`define DSCIDT_CLS_MAC 4'h5
`define DSCIDT_CLS_DSPSH 4'h6
`define DSCIDT_CLS_BRANCH_OP 4'h7
`define DSCIDT_CLS_BRCOND 4'h8
`define DSCIDT_CLS_CALLIND 4'h9
`define DSCIDT_CLS_TABLE 4'hA
`define DSCIDT_CLS_RETURN 4'hB
`define DSCIDT_CLS_SKIP 4'hC
`define DSCIDT_CLS_MOVD 4'hD
`define DSCIDT_CLS_TWOWORD 4'hE
`define DSCIDT_SRC_LSB 0
`define DSCIDT_SMODE_LSB 4
`define DSCIDT_DST_LSB 7
`define DSCIDT_DMODE_LSB 11
`define DSCIDT_SIZE_LSB 14
`define DSCIDT_FWREG_BIT 13
`define DSCIDT_BITSEL_LSB 8
`define DSCIDT_BITIND_BIT 12
`define DSCIDT_LDST_LSB 10
`define DSCIDT_LSEP_BIT 14
`define DSCIDT_LBYTE_BIT 15
`define DSCIDT_ACC_BIT 15
`define DSCIDT_MPAIR_LSB 12
`define DSCIDT_XPF_LSB 8
`define DSCIDT_YPF_LSB 4
`define DSCIDT_WBK_LSB 2
`define DSCIDT_SHREG_BIT 14
`define DSCIDT_RETI_BIT 1
`define DSCIDT_SIZE_WORD 2'h0
`define DSCIDT_SIZE_BYTE 2'h1
`define DSCIDT_SIZE_DBL 2'h2
`define DSCIDT_WBK_NONE 2'h0
`define DSCIDT_WBK_W13 2'h1
`define DSCIDT_WBK_W13PI 2'h2
`define DSCIDT_BYTE_LIT_MAX 10'h0FF
`define DSCIDT_CYC_ONE 2'h1
`define DSCIDT_CYC_TWO 2'h2
`define DSCIDT_CYC_THREE 2'h3
`define DSCIDT_RST_FLAGS 4'h0
`define DSCIDT_RST_ZERO 1'b1
`endif

/* File: tb/dscidt_checker.sv */
// checker for fetch pairing, cycle timing and flag writes of the decoder
// assumes it is bound to the decoder and sees only its ports
`timescale 1ns/100ps
module dscidt_checker (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire [23:0] instr_word,
    input wire instr_valid,
    input wire cond_true,
    input wire next_two_word,
    input wire [3:0] dsp_flag_we,
    input wire [3:0] dsp_flag_val,
    input wire [3:0] mcu_flag_we,
    input wire [3:0] mcu_flag_val,
    input wire zero_we,
    input wire result_zero,
    input wire [3:0] mcu_flags_q,
    input wire zero_flag_q,
    input wire fetch_rdy_q,
    input wire dec_valid_q,
    input wire nop_q,
    input wire [7:0] opcode_q,
    input wire [47:0] long_instr_q,
    input wire [1:0] cycles_q,
    input wire word2_err_q,
    input wire [3:0] dsp_flags_q
);
    reg pend_q;
    wire take = ce && instr_valid && fetch_rdy_q;
    wire first = instr_word[23:20] == 4'hE;
    wire one = take && !pend_q && !first;
    // a second word must never be mistaken for a lone instruction here
    always @(posedge mclk) begin
        if (rst)
            pend_q <= 1'b0;
        else if (take)
            pend_q <= !pend_q && first;
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_gap;
        nop_q && !fetch_rdy_q;
    endsequence
    sequence s_resume;
        !nop_q && fetch_rdy_q;
    endsequence
    a_dec_opcode: assert property (one |=> dec_valid_q
        && opcode_q == $past(instr_word[23:16])) else $error("opcode");
    a_pair_join: assert property (take && pend_q |=> dec_valid_q
        && long_instr_q[23:0] == $past(instr_word) && cycles_q == 2'h2)
        else $error("pair join");
    a_word2_zero: assert property (take && pend_q |=>
        word2_err_q == ($past(instr_word[23:16]) != 8'h00))
        else $error("second word check");
    a_branch_two: assert property (one && instr_word[23:20] == 4'h7
        |=> cycles_q == 2'h2 ##0 s_gap ##1 s_resume) else $error("branch");
    a_ret_three: assert property (one && instr_word[23:20] == 4'hB
        && instr_word[1] |=> cycles_q == 2'h3 ##0 s_gap[*2] ##1 s_resume)
        else $error("interrupt return");
    a_skip_count: assert property (one && instr_word[23:20] == 4'hC
        |=> cycles_q == (!$past(cond_true) ? 2'h1
        : $past(next_two_word) ? 2'h3 : 2'h2)) else $error("skip");
    a_nop_stall: assert property (nop_q |-> !fetch_rdy_q)
        else $error("fetch during no-op");
    a_dsp_write: assert property (ce && |dsp_flag_we |=>
        ((dsp_flags_q ^ $past(dsp_flag_val)) & $past(dsp_flag_we)) == 4'h0)
        else $error("dsp flag write");
    a_mcu_write: assert property (ce && |mcu_flag_we |=>
        ((mcu_flags_q ^ $past(mcu_flag_val)) & $past(mcu_flag_we)) == 4'h0)
        else $error("mcu flag write");
    a_zero_clear: assert property (ce && zero_we && !result_zero |=>
        !zero_flag_q) else $error("sticky zero clear");
    a_zero_hold: assert property (!(ce && zero_we && !result_zero) |=>
        $stable(zero_flag_q)) else $error("sticky zero hold");
endmodule
bind dscidt_decode dscidt_checker u_chk (.*);

/* File: tb/dscidt_pmem.sv */
// program memory model handing stored words to the decoder
// assumes the bench fills mem and len before raising run
`timescale 1ns/100ps
module dscidt_pmem (
    input wire mclk,
    input wire run,
    input wire gap,
    input wire ce,
    input wire fetch_rdy,
    output reg [23:0] instr_word = 24'h000000,
    output reg instr_valid = 1'b0,
    output reg cond_true = 1'b0,
    output reg next_two_word = 1'b0
);
    reg [25:0] mem [0:255];
    integer len = 0;
    integer addr = 0;
    reg tk = 1'b0;
    always @(posedge mclk) begin
        tk <= instr_valid && ce && fetch_rdy;
        if (instr_valid && ce && fetch_rdy)
            addr <= addr + 1;
    end
    // an offered word is held until taken; an idle bus inverts the word on every idle cycle
    always @(negedge mclk) begin
        if (run && addr < len && ((instr_valid && !tk) || !gap)) begin
            {next_two_word, cond_true, instr_word} <= mem[addr];
            instr_valid <= 1'b1;
        end else begin
            instr_word <= ~instr_word;
            instr_valid <= 1'b0;
        end
    end
endmodule

/* File: tb/tb.sv */
// bench: corner and random program through the decoder, fields checked
// assumes the program memory model and the bound checker
`timescale 1ns/100ps
module tb;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg ce = 1'b1;
    reg run = 1'b0;
    reg gap = 1'b0;
    reg zero_we = 1'b0;
    reg result_zero = 1'b0;
    reg [3:0] mcu_flag_we = 4'h0;
    reg [3:0] mcu_flag_val = 4'h0;
    reg [3:0] dsp_flag_we = 4'h0;
    reg [3:0] dsp_flag_val = 4'h0;
    wire [23:0] instr_word;
    wire instr_valid, cond_true, next_two_word;
    wire fetch_rdy_q, dec_valid_q, nop_q, pc_change_q, bit_indirect_q;
    wire dest_default_accum_reg_zero_q, lit_range_err_q, addr_lsb_err_q;
    wire word2_err_q, acc_sel_q, shift_from_reg_q, shadow_q, zero_flag_q;
    wire [3:0] instr_class_q, base_work_reg_q, source_work_reg_q, xpf_q;
    wire [3:0] dest_work_reg_q, bit_select_field_q, ypf_q, mcu_flags_q;
    wire [3:0] dsp_flags_q;
    wire [2:0] src_mode_q, dest_mode_q, mul_pair_q;
    wire [1:0] cycles_q, acc_writeback_dest_q, size_q;
    wire [7:0] opcode_q;
    wire [47:0] long_instr_q;
    wire [12:0] file_addr_q;
    wire [9:0] unsigned_literal_ten_q;
    wire [22:0] unsigned_literal_twentythree_q;
    wire [5:0] shift_amount_q;
    reg [25:0] iw [0:127];
    reg [23:0] i2 [0:127];
    reg [25:0] e;
    reg [23:0] w2;
    integer seed = 32'hB032;
    integer ni = 0;
    integer num_errors = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer i;
    integer k;
    dscidt_decode DUT (.*);
    dscidt_pmem P (.fetch_rdy(fetch_rdy_q), .*);
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    // flag writes and fetch gaps change every cycle once out of reset
    always @(negedge mclk)
        if (!rst)
            {mcu_flag_we, mcu_flag_val, dsp_flag_we, dsp_flag_val, zero_we,
                result_zero, gap} <= $random(seed);
    function [1:0] exp_cyc(input [25:0] x);
        case (x[23:20])
            4'h7, 4'h9, 4'hA, 4'hD, 4'hE: exp_cyc = 2'h2;
            4'h8: exp_cyc = x[24] ? 2'h2 : 2'h1;
            4'hB: exp_cyc = x[1] ? 2'h3 : 2'h2;
            4'hC: exp_cyc = !x[24] ? 2'h1 : x[25] ? 2'h3 : 2'h2;
            default: exp_cyc = 2'h1;
        endcase
    endfunction
    function exp_pc(input [25:0] x);
        case (x[23:20])
            4'h7, 4'h9, 4'hB, 4'hE: exp_pc = 1'b1;
            4'h8, 4'hC: exp_pc = x[24];
            default: exp_pc = 1'b0;
        endcase
    endfunction
    task chk(input string n, input [47:0] g, input [47:0] x);
        begin
            checks_done = checks_done + 1;
            if (g !== x) begin
                num_errors = num_errors + 1;
                $display("unexpected %s exp %h got %h", n, x, g);
            end
        end
    endtask
    task add(input [25:0] x, input [23:0] y);
        begin
            iw[ni] = x;
            i2[ni] = y;
            ni = ni + 1;
            P.mem[P.len] = x;
            P.len = P.len + 1;
            if (x[23:20] == 4'hE) begin
                P.mem[P.len] = {2'b00, y};
                P.len = P.len + 1;
            end
        end
    endtask
    task end_sim;
        begin
            $display("errors %0d checks %0d", num_errors, checks_done);
            if (num_errors == 0 && checks_done > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        add(26'h000ABCD, 24'h000000);
        add(26'h0E12345, 24'h5A0001);
        add(26'h0E00000, 24'h000000);
        add(26'h0B00002, 24'h000000);
        add(26'h3C00000, 24'h000000);
        add(26'h040C3FF, 24'h000000);
        add(26'h050000C, 24'h000000);
        add(26'h0700000, 24'h000000);
        for (i = 0; i < 60; i = i + 1) begin
            e = $random(seed);
            w2 = $random(seed);
            add(e, w2[23] ? w2 : {8'h00, w2[15:0]});
        end
        repeat (12) @(negedge mclk);
        chk("ready", fetch_rdy_q, 1'b1);
        chk("size", size_q, 2'h0);
        chk("flags", {mcu_flags_q, zero_flag_q, dsp_flags_q}, 9'h010);
        rst = 1'b0;
        run = 1'b1;
        for (i = 0; i < ni; i = i + 1) begin
            e = iw[i];
            w2 = i2[i];
            k = 0;
            @(negedge mclk);
            while (dec_valid_q !== 1'b1 && k < 30) begin
                @(negedge mclk);
                k = k + 1;
            end
            chk("decode", dec_valid_q, 1'b1);
            chk("opcode", opcode_q, e[23:16]);
            chk("class", instr_class_q, e[23:20]);
            chk("pc change", pc_change_q, exp_pc(e));
            chk("long", long_instr_q, e[23:20] == 4'hE ?
                {e[23:0], w2} : e[23:0]);
            chk("cycles", cycles_q, exp_cyc(e));
            chk("base", base_work_reg_q, e[19:16]);
            if (e[23:20] != 4'hE) begin
                chk("rs", {src_mode_q, source_work_reg_q}, e[6:0]);
                chk("file", file_addr_q, e[12:0]);
                chk("lit_ten", unsigned_literal_ten_q, e[9:0]);
                chk("dest", {dest_work_reg_q, dest_mode_q},
                    e[23:20] == 4'h4 ? {e[14] ? e[13:10] : e[19:16], 3'h0} :
                    {e[10:7], e[13:11]});
                chk("pf", {mul_pair_q, xpf_q, ypf_q}, e[14:4]);
                chk("shift amount", shift_amount_q, e[5:0]);
                chk("shadow", shadow_q, e[23:20] == 4'hB && e[0]);
                chk("size any", size_q,
                    e[23:20] == 4'h4 ? {1'b0, e[15]} :
                    &e[15:14] ? 2'h0 : e[15:14]);
            end
            case (e[23:20])
                4'h0: chk("pc", pc_change_q, 1'b0);
                4'h1: chk("size", size_q, &e[15:14] ? 2'h0 : e[15:14]);
                4'h2: chk("fdst", dest_default_accum_reg_zero_q, e[13]);
                4'h3: chk("bit", {bit_indirect_q, bit_select_field_q},
                    e[12:8]);
                4'h4: chk("lit", {lit_range_err_q, dest_work_reg_q},
                    {e[15] && e[9:0] > 10'h0FF, e[14] ? e[13:10] : e[19:16]});
                4'h5: chk("mac", {acc_sel_q, acc_writeback_dest_q},
                    {e[15], &e[3:2] ? 2'h0 : e[3:2]});
                4'h6: chk("shift", shift_from_reg_q, e[14]);
                4'hE: chk("lit_long", {word2_err_q, addr_lsb_err_q,
                    unsigned_literal_twentythree_q},
                    {|w2[23:16], w2[0], e[6:0], w2[15:1], 1'b0});
                default: ;
            endcase
        end
        end_sim;
    end
endmodule
